// ===== rtl/alu_pkg.sv
package alu_pkg;

	typedef enum logic [4:0] {
		OP_ADD = 5'h00,
		OP_ADD_CARRY = 5'h01,
		OP_PAIR_PLUS_IMMEDIATE = 5'h02,
		OP_SUB = 5'h03,
		OP_MINUS_CONSTANT = 5'h04,
		OP_MINUS_WITH_BORROW = 5'h05,
		OP_MINUS_CONSTANT_WITH_BORROW = 5'h06,
		OP_PAIR_MINUS_IMMEDIATE = 5'h07,
		OP_AND = 5'h08,
		OP_MASK_AND_CONSTANT = 5'h09,
		OP_OR = 5'h0a,
		OP_MERGE_OR_CONSTANT = 5'h0b,
		OP_EXCLUSIVE_OR = 5'h0c,
		OP_ONES_COMPLEMENT = 5'h0d,
		OP_TWOS_COMPLEMENT = 5'h0e,
		OP_SET_BITS_BY_MASK = 5'h0f,
		OP_CLEAR_BITS_BY_MASK = 5'h10,
		OP_PLUS_ONE_STEP = 5'h11,
		OP_MINUS_ONE_STEP = 5'h12,
		OP_ZERO_SIGN_TEST = 5'h13,
		OP_ZERO_REGISTER = 5'h14,
		OP_ALL_ONES_REGISTER = 5'h15,
		OP_PRODUCT_UNSIGNED = 5'h16,
		OP_PRODUCT_SIGNED = 5'h17,
		OP_PRODUCT_MIXED_SIGN = 5'h18,
		OP_FRACTIONAL_PRODUCT_UNSIGNED = 5'h19,
		OP_FRACTIONAL_PRODUCT_SIGNED = 5'h1a,
		OP_FRACTIONAL_PRODUCT_MIXED = 5'h1b
	} op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_SECOND = 2'h2
	} state_t;

	// flag vector bit positions
	localparam int FLAG_Z = 0;
	localparam int FLAG_C = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_H = 4;
	localparam int FLAG_S = 5;
	localparam int FLAG_W = 6;

	localparam logic [5:0] MASK_ARITH = 6'h1f;
	localparam logic [5:0] MASK_WORD = 6'h2f;
	localparam logic [5:0] MASK_LOGIC = 6'h0d;
	localparam logic [5:0] MASK_COMPLEMENT = 6'h0f;
	localparam logic [5:0] MASK_PRODUCT = 6'h03;
	localparam logic [5:0] MASK_NONE = 6'h00;

	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ONES = 8'hff;
	localparam logic [7:0] BYTE_ONE = 8'h01;
	localparam logic [7:0] BYTE_MIN_NEG = 8'h80;
	localparam logic [7:0] BYTE_MAX_POS = 8'h7f;
	localparam logic [15:0] WORD_ZERO = 16'h0000;

	function automatic logic is_two_cycle(input op_t op);
		return (op == OP_PAIR_PLUS_IMMEDIATE) || (op == OP_PAIR_MINUS_IMMEDIATE) ||
			(op >= OP_PRODUCT_UNSIGNED && op <= OP_FRACTIONAL_PRODUCT_MIXED);
	endfunction

endpackage

// ===== rtl/eight_bit_arith_logic_unit.sv
`timescale 1ns/1ps
module eight_bit_arith_logic_unit (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic start,
	input wire alu_pkg::op_t op,
	input wire logic [7:0] dst_val,
	input wire logic [7:0] src_val,
	input wire logic [7:0] pair_hi,
	input wire logic [7:0] imm,
	input wire logic carry_in,
	output logic busy,
	output logic done,
	output logic [7:0] res_lo,
	output logic [7:0] res_hi,
	output logic wr_dst,
	output logic wr_pair,
	output logic wr_prod,
	output logic [5:0] flags,
	output logic [5:0] flag_we
);
	import alu_pkg::*;

	typedef struct packed {
		state_t fsm;
		logic busy;
		logic done;
		logic [7:0] res_lo;
		logic [7:0] res_hi;
		logic wr_dst;
		logic wr_pair;
		logic wr_prod;
		logic pend_pair;
		logic pend_prod;
		logic [5:0] flags;
		logic [5:0] flag_we;
	} core_t;

	localparam core_t CORE_RESET = '{fsm: ST_IDLE, busy: 1'b0, done: 1'b0,
		res_lo: BYTE_ZERO, res_hi: BYTE_ZERO, wr_dst: 1'b0, wr_pair: 1'b0,
		wr_prod: 1'b0, pend_pair: 1'b0, pend_prod: 1'b0, flags: MASK_NONE,
		flag_we: MASK_NONE};

	core_t cur;
	core_t next_cur;

	// returns {half, overflow, carry, result}
	function automatic logic [10:0] arith8(input logic [7:0] a, input logic [7:0] b,
		input logic cin, input logic sub);
		logic [8:0] w;
		logic [4:0] hw;
		logic v;
		if (sub) begin
			w = {1'b0, a} - {1'b0, b} - {8'h00, cin};
			hw = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
			v = (a[7] & ~b[7] & ~w[7]) | (~a[7] & b[7] & w[7]);
		end else begin
			w = {1'b0, a} + {1'b0, b} + {8'h00, cin};
			hw = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
			v = (a[7] & b[7] & ~w[7]) | (~a[7] & ~b[7] & w[7]);
		end
		return {hw[4], v, w[8], w[7:0]};
	endfunction

	function automatic logic [5:0] nz_flags(input logic [7:0] r, input logic c,
		input logic v, input logic h);
		logic [5:0] f;
		f = MASK_NONE;
		f[FLAG_Z] = (r == BYTE_ZERO);
		f[FLAG_C] = c;
		f[FLAG_N] = r[7];
		f[FLAG_V] = v;
		f[FLAG_H] = h;
		f[FLAG_S] = r[7] ^ v;
		return f;
	endfunction

	always_comb begin
		logic [10:0] ar;
		logic [7:0] r8;
		logic [16:0] w17;
		logic [15:0] pair;
		logic [15:0] ea;
		logic [15:0] eb;
		logic [15:0] prod;
		logic [15:0] r16;
		logic a_signed;
		logic b_signed;
		logic frac;
		logic [5:0] f;
		logic [5:0] m;
		ar = '0;
		r8 = BYTE_ZERO;
		w17 = '0;
		pair = {pair_hi, dst_val};
		a_signed = 1'b0;
		b_signed = 1'b0;
		frac = 1'b0;
		f = MASK_NONE;
		m = MASK_NONE;
		r16 = WORD_ZERO;
		ea = WORD_ZERO;
		eb = WORD_ZERO;
		prod = WORD_ZERO;
		next_cur = cur;
		next_cur.done = 1'b0;
		next_cur.wr_dst = 1'b0;
		next_cur.wr_pair = 1'b0;
		next_cur.wr_prod = 1'b0;

		b_signed = (op == OP_PRODUCT_SIGNED) || (op == OP_FRACTIONAL_PRODUCT_SIGNED);
		// the mixed forms sign the destination operand only
		a_signed = b_signed || (op == OP_PRODUCT_MIXED_SIGN) ||
			(op == OP_FRACTIONAL_PRODUCT_MIXED);
		frac = (op >= OP_FRACTIONAL_PRODUCT_UNSIGNED);
		ea = a_signed ? {{8{dst_val[7]}}, dst_val} : {BYTE_ZERO, dst_val};
		eb = b_signed ? {{8{src_val[7]}}, src_val} : {BYTE_ZERO, src_val};
		// low 16 bits of the extended product are exact for every sign mix
		prod = 16'(ea * eb);
		w17 = (op == OP_PAIR_MINUS_IMMEDIATE) ? ({1'b0, pair} - {9'h000, imm}) :
			({1'b0, pair} + {9'h000, imm});

		case (op)
			OP_ADD, OP_ADD_CARRY: begin
				ar = arith8(dst_val, src_val, (op == OP_ADD_CARRY) & carry_in, 1'b0);
				m = MASK_ARITH;
			end
			OP_SUB, OP_MINUS_WITH_BORROW: begin
				ar = arith8(dst_val, src_val, (op == OP_MINUS_WITH_BORROW) & carry_in, 1'b1);
				m = MASK_ARITH;
			end
			OP_MINUS_CONSTANT, OP_MINUS_CONSTANT_WITH_BORROW: begin
				ar = arith8(dst_val, imm, carry_in & (op != OP_MINUS_CONSTANT), 1'b1);
				m = MASK_ARITH;
			end
			OP_TWOS_COMPLEMENT: begin
				ar = arith8(BYTE_ZERO, dst_val, 1'b0, 1'b1);
				m = MASK_ARITH;
			end
			OP_AND, OP_MASK_AND_CONSTANT: begin
				ar = {3'h0, dst_val & ((op == OP_AND) ? src_val : imm)};
				m = MASK_LOGIC;
			end
			OP_OR, OP_MERGE_OR_CONSTANT, OP_SET_BITS_BY_MASK: begin
				ar = {3'h0, dst_val | ((op == OP_OR) ? src_val : imm)};
				m = MASK_LOGIC;
			end
			OP_EXCLUSIVE_OR: begin
				ar = {3'h0, dst_val ^ src_val};
				m = MASK_LOGIC;
			end
			OP_ONES_COMPLEMENT: begin
				// carry always set after complement
				ar = {3'h1, BYTE_ONES - dst_val};
				m = MASK_COMPLEMENT;
			end
			OP_CLEAR_BITS_BY_MASK: begin
				ar = {3'h0, dst_val & (BYTE_ONES - imm)};
				m = MASK_LOGIC;
			end
			OP_PLUS_ONE_STEP: begin
				r8 = dst_val + BYTE_ONE;
				ar = {1'b0, dst_val == BYTE_MAX_POS, 1'b0, r8};
				m = MASK_LOGIC;
			end
			OP_MINUS_ONE_STEP: begin
				r8 = dst_val - BYTE_ONE;
				ar = {1'b0, dst_val == BYTE_MIN_NEG, 1'b0, r8};
				m = MASK_LOGIC;
			end
			OP_ZERO_SIGN_TEST: begin
				ar = {3'h0, dst_val & dst_val};
				m = MASK_LOGIC;
			end
			OP_ZERO_REGISTER: begin
				ar = {3'h0, dst_val ^ dst_val};
				m = MASK_LOGIC;
			end
			OP_ALL_ONES_REGISTER: begin
				ar = {3'h0, BYTE_ONES};
				m = MASK_NONE;
			end
			default: begin
			end
		endcase
		f = nz_flags(ar[7:0], ar[8], ar[9], ar[10]);

		if (is_two_cycle(op)) begin
			if (op == OP_PAIR_PLUS_IMMEDIATE || op == OP_PAIR_MINUS_IMMEDIATE) begin
				r16 = w17[15:0];
				f = MASK_NONE;
				f[FLAG_Z] = (r16 == WORD_ZERO);
				f[FLAG_C] = w17[16];
				f[FLAG_N] = r16[15];
				f[FLAG_V] = (op == OP_PAIR_MINUS_IMMEDIATE) ? (pair[15] & ~r16[15]) :
					(~pair[15] & r16[15]);
				f[FLAG_S] = f[FLAG_N] ^ f[FLAG_V];
				m = MASK_WORD;
			end else begin
				r16 = frac ? {prod[14:0], 1'b0} : prod;
				f = MASK_NONE;
				f[FLAG_Z] = (r16 == WORD_ZERO);
				f[FLAG_C] = prod[15];
				m = MASK_PRODUCT;
			end
		end

		case (cur.fsm)
			ST_IDLE: begin
				if (start) begin
					next_cur.flags = f;
					next_cur.flag_we = m;
					if (is_two_cycle(op)) begin
						// hold the result a cycle; strobes fire with done
						next_cur.fsm = ST_SECOND;
						next_cur.busy = 1'b1;
						next_cur.res_lo = r16[7:0];
						next_cur.res_hi = r16[15:8];
						next_cur.pend_pair = (op == OP_PAIR_PLUS_IMMEDIATE) ||
							(op == OP_PAIR_MINUS_IMMEDIATE);
						next_cur.pend_prod = !next_cur.pend_pair;
					end else begin
						next_cur.done = 1'b1;
						next_cur.res_lo = ar[7:0];
						next_cur.res_hi = BYTE_ZERO;
						next_cur.wr_dst = (op <= OP_ALL_ONES_REGISTER);
					end
				end
			end
			ST_SECOND: begin
				next_cur.fsm = ST_IDLE;
				next_cur.busy = 1'b0;
				next_cur.done = 1'b1;
				next_cur.wr_pair = cur.pend_pair;
				next_cur.wr_prod = cur.pend_prod;
			end
			default: begin
				next_cur = CORE_RESET;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cur <= CORE_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	assign busy = cur.busy;
	assign done = cur.done;
	assign res_lo = cur.res_lo;
	assign res_hi = cur.res_hi;
	assign wr_dst = cur.wr_dst;
	assign wr_pair = cur.wr_pair;
	assign wr_prod = cur.wr_prod;
	assign flags = cur.flags;
	assign flag_we = cur.flag_we;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	wire logic take = start && !busy;

	add_result_a: assert property (take && op == OP_ADD |=> done && wr_dst &&
		res_lo == 8'($past(dst_val) + $past(src_val)) && flag_we == MASK_ARITH)
		else $error("register add result wrong");
	sub_borrow_a: assert property (take && op == OP_MINUS_WITH_BORROW |=>
		res_lo == 8'($past(dst_val) - $past(src_val) - {7'h00, $past(carry_in)}))
		else $error("subtract with borrow wrong");
	pair_timing_a: assert property (take && op == OP_PAIR_PLUS_IMMEDIATE |=>
		busy && !done ##1 done && wr_pair && flag_we == MASK_WORD)
		else $error("pair add timing wrong");
	pair_minus_a: assert property (take && op == OP_PAIR_MINUS_IMMEDIATE |->
		##2 {res_hi, res_lo} == 16'($past({pair_hi, dst_val}, 2) - {8'h00, $past(imm, 2)}))
		else $error("pair subtract value wrong");
	logic_flags_a: assert property (take && op == OP_AND |=> flag_we == MASK_LOGIC &&
		!flags[FLAG_V] && flags[FLAG_Z] == (res_lo == BYTE_ZERO))
		else $error("logic flags wrong");
	complement_a: assert property (take && op == OP_ONES_COMPLEMENT |=>
		res_lo == ~$past(dst_val) && flags[FLAG_C])
		else $error("complement wrong");
	clear_mask_a: assert property (take && op == OP_CLEAR_BITS_BY_MASK |=>
		res_lo == ($past(dst_val) & ~$past(imm)))
		else $error("mask clear wrong");
	step_carry_a: assert property (take && op == OP_PLUS_ONE_STEP |=>
		!flag_we[FLAG_C] && res_lo == 8'($past(dst_val) + BYTE_ONE))
		else $error("increment touches carry or wrong value");
	negate_a: assert property (take && op == OP_TWOS_COMPLEMENT |=>
		res_lo == 8'(BYTE_ZERO - $past(dst_val)) && flags[FLAG_C] == (res_lo != BYTE_ZERO))
		else $error("negate wrong");
	all_ones_a: assert property (take && op == OP_ALL_ONES_REGISTER |=>
		res_lo == BYTE_ONES && flag_we == MASK_NONE && wr_dst)
		else $error("all ones load wrong");
	product_a: assert property (take && op == OP_PRODUCT_UNSIGNED |-> ##1 !done ##1
		done && wr_prod && {res_hi, res_lo} == 16'($past(dst_val, 2) * $past(src_val, 2)))
		else $error("unsigned product wrong");
	frac_zero_a: assert property (take && op == OP_FRACTIONAL_PRODUCT_UNSIGNED |=>
		!res_lo[0] && flags[FLAG_Z] == ({res_hi, res_lo} == WORD_ZERO))
		else $error("fractional product shift wrong");

	add_cov_c: cover property (take && op == OP_ADD_CARRY ##1 done);
	mixed_cov_c: cover property (take && op == OP_PRODUCT_MIXED_SIGN ##2 done);
	fmix_cov_c: cover property (take && op == OP_FRACTIONAL_PRODUCT_MIXED ##2 wr_prod);
	pair_cov_c: cover property (take && op == OP_PAIR_MINUS_IMMEDIATE ##2 wr_pair);

endmodule

// ===== sim/eight_bit_arith_logic_unit_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module eight_bit_arith_logic_unit_tb_top;
	import alu_pkg::*;
	typedef struct packed {
		op_t op;
		logic [7:0] d, s, h, k;
		logic c;
		logic [15:0] r;
		logic [5:0] f, w;
	} row_t;
	localparam row_t rows[28] = '{
		'{OP_ADD, 8'h0f, 8'h01, 8'h00, 8'h00, 1'b1, 16'h0010, 6'h10, MASK_ARITH},
		'{OP_ADD_CARRY, 8'hff, 8'h00, 8'h00, 8'h00, 1'b1, 16'h0000, 6'h13, MASK_ARITH},
		'{OP_PAIR_PLUS_IMMEDIATE, 8'hff, 8'h00, 8'hff, 8'h01, 1'b0, 16'h0000, 6'h03, MASK_WORD},
		'{OP_SUB, 8'h80, 8'h01, 8'h00, 8'h00, 1'b1, 16'h007f, 6'h18, MASK_ARITH},
		'{OP_MINUS_WITH_BORROW, 8'h10, 8'h01, 8'h00, 8'h00, 1'b1, 16'h000e, 6'h10,
			MASK_ARITH},
		'{OP_MINUS_CONSTANT, 8'h05, 8'h00, 8'h00, 8'h05, 1'b0, 16'h0000, 6'h01, MASK_ARITH},
		'{OP_MINUS_CONSTANT_WITH_BORROW, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 16'h00ff, 6'h16,
			MASK_ARITH},
		'{OP_PAIR_MINUS_IMMEDIATE, 8'h00, 8'h00, 8'h00, 8'h01, 1'b0, 16'hffff, 6'h26, MASK_WORD},
		'{OP_AND, 8'hf0, 8'h8f, 8'h00, 8'h00, 1'b1, 16'h0080, 6'h04, MASK_LOGIC},
		'{OP_MASK_AND_CONSTANT, 8'h0f, 8'h00, 8'h00, 8'hf0, 1'b0, 16'h0000, 6'h01, MASK_LOGIC},
		'{OP_OR, 8'h01, 8'h80, 8'h00, 8'h00, 1'b0, 16'h0081, 6'h04, MASK_LOGIC},
		'{OP_MERGE_OR_CONSTANT, 8'h00, 8'hff, 8'h00, 8'h00, 1'b0, 16'h0000, 6'h01, MASK_LOGIC},
		'{OP_EXCLUSIVE_OR, 8'haa, 8'h55, 8'h00, 8'h00, 1'b0, 16'h00ff, 6'h04, MASK_LOGIC},
		'{OP_ONES_COMPLEMENT, 8'hff, 8'h00, 8'h00, 8'h00, 1'b0, 16'h0000, 6'h03, MASK_COMPLEMENT},
		'{OP_TWOS_COMPLEMENT, 8'h80, 8'h00, 8'h00, 8'h00, 1'b0, 16'h0080, 6'h0e, MASK_ARITH},
		'{OP_SET_BITS_BY_MASK, 8'h10, 8'h00, 8'h00, 8'h01, 1'b0, 16'h0011, 6'h00, MASK_LOGIC},
		'{OP_CLEAR_BITS_BY_MASK, 8'hff, 8'h00, 8'h00, 8'h0f, 1'b0, 16'h00f0, 6'h04, MASK_LOGIC},
		'{OP_PLUS_ONE_STEP, 8'h7f, 8'h00, 8'h00, 8'h00, 1'b1, 16'h0080, 6'h0c, MASK_LOGIC},
		'{OP_MINUS_ONE_STEP, 8'h80, 8'h00, 8'h00, 8'h00, 1'b1, 16'h007f, 6'h08, MASK_LOGIC},
		'{OP_ZERO_SIGN_TEST, 8'h00, 8'h33, 8'h00, 8'h00, 1'b0, 16'h0000, 6'h01, MASK_LOGIC},
		'{OP_ZERO_REGISTER, 8'h5a, 8'h00, 8'h00, 8'h00, 1'b0, 16'h0000, 6'h01, MASK_LOGIC},
		'{OP_ALL_ONES_REGISTER, 8'h12, 8'h00, 8'h00, 8'h00, 1'b1, 16'h00ff, 6'h00, MASK_NONE},
		'{OP_PRODUCT_UNSIGNED, 8'hff, 8'hff, 8'h00, 8'h00, 1'b0, 16'hfe01, 6'h02, MASK_PRODUCT},
		'{OP_PRODUCT_SIGNED, 8'hff, 8'h01, 8'h00, 8'h00, 1'b0, 16'hffff, 6'h02, MASK_PRODUCT},
		'{OP_PRODUCT_MIXED_SIGN, 8'hff, 8'h02, 8'h00, 8'h00, 1'b0, 16'hfffe, 6'h02, MASK_PRODUCT},
		'{OP_FRACTIONAL_PRODUCT_UNSIGNED, 8'h80, 8'h80, 8'h00, 8'h00, 1'b0, 16'h8000, 6'h00,
			MASK_PRODUCT},
		'{OP_FRACTIONAL_PRODUCT_SIGNED, 8'h80, 8'h40, 8'h00, 8'h00, 1'b0, 16'hc000, 6'h02,
			MASK_PRODUCT},
		'{OP_FRACTIONAL_PRODUCT_MIXED, 8'hc0, 8'h80, 8'h00, 8'h00, 1'b0, 16'hc000, 6'h02,
			MASK_PRODUCT}
	};
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic start = 1'b0;
	op_t op = OP_ADD;
	logic [7:0] dst_val = 8'h00, src_val = 8'h00, pair_hi = 8'h00, imm = 8'h00;
	logic carry_in = 1'b0;
	logic busy, done, wr_dst, wr_pair, wr_prod;
	logic [7:0] res_lo, res_hi;
	logic [5:0] flags, flag_we;
	logic [15:0] stored;
	logic [2:0] last_wr;
	int miscompares = 0;
	int total_checks = 0;
	eight_bit_arith_logic_unit uut (.mclk(mclk), .arst_n(arst_n), .start(start), .op(op),
		.dst_val(dst_val), .src_val(src_val), .pair_hi(pair_hi), .imm(imm), .carry_in(carry_in),
		.busy(busy), .done(done), .res_lo(res_lo), .res_hi(res_hi), .wr_dst(wr_dst),
		.wr_pair(wr_pair), .wr_prod(wr_prod), .flags(flags), .flag_we(flag_we));
	reg_file_model partner (.mclk(mclk), .arst_n(arst_n), .wr_dst(wr_dst), .wr_pair(wr_pair),
		.wr_prod(wr_prod), .res_lo(res_lo), .res_hi(res_hi), .stored(stored), .last_wr(last_wr));
	initial begin
		forever #25 mclk = ~mclk;
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// one request; byte ops answer right after the take edge, long ops one edge later
	task automatic run(input row_t r);
		int n;
		logic two;
		two = (r.w == MASK_WORD) || (r.w == MASK_PRODUCT);
		@(posedge mclk);
		start <= 1'b1;
		op <= r.op;
		dst_val <= r.d;
		src_val <= r.s;
		pair_hi <= r.h;
		imm <= r.k;
		carry_in <= r.c;
		@(posedge mclk);
		start <= 1'b0;
		#1;
		`CHK(busy, two)
		n = 0;
		while (done !== 1'b1 && n < 10) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n == 10) begin
			miscompares++;
			end_of_test();
		end
		`CHK(n, int'(two))
		`CHK({res_hi, res_lo}, r.r)
		`CHK(flags & r.w, r.f)
		`CHK(flag_we, r.w)
		@(posedge mclk);
		#1;
		`CHK(last_wr, (r.w == MASK_PRODUCT) ? 3'h4 : (r.w == MASK_WORD) ? 3'h2 : 3'h1)
		`CHK(stored, r.r)
	endtask
	initial begin
		repeat (8) @(posedge mclk);
		arst_n <= 1'b1;
		// undefined code: answers but writes nothing and claims no flag
		@(posedge mclk);
		start <= 1'b1;
		op <= op_t'(5'h1f);
		@(posedge mclk);
		start <= 1'b0;
		#1;
		`CHK({done, flag_we}, 7'h40)
		@(posedge mclk);
		#1;
		`CHK(last_wr, 3'h0)
		foreach (rows[i]) begin
			run(rows[i]);
		end
		// back-to-back byte ops, one per edge
		@(posedge mclk);
		start <= 1'b1;
		op <= OP_ADD;
		{dst_val, src_val, carry_in} <= {8'h01, 8'h01, 1'b0};
		@(posedge mclk);
		{dst_val, src_val} <= {8'h03, 8'h04};
		#1;
		`CHK({done, res_lo}, 9'h102)
		@(posedge mclk);
		start <= 1'b0;
		#1;
		`CHK({done, res_lo}, 9'h107)
		// a request while busy must be ignored
		@(posedge mclk);
		start <= 1'b1;
		op <= OP_PRODUCT_UNSIGNED;
		{dst_val, src_val} <= {8'h02, 8'h03};
		@(posedge mclk);
		op <= OP_ADD;
		{dst_val, src_val} <= {8'h10, 8'h10};
		#1;
		`CHK(busy, 1'b1)
		@(posedge mclk);
		start <= 1'b0;
		#1;
		`CHK({done, wr_prod, res_hi, res_lo}, 18'h3_0006)
		@(posedge mclk);
		#1;
		`CHK(done, 1'b0)
		// reset in mid-operation clears every output
		@(posedge mclk);
		start <= 1'b1;
		op <= OP_PRODUCT_SIGNED;
		@(posedge mclk);
		start <= 1'b0;
		arst_n <= 1'b0;
		#1;
		`CHK({busy, done, wr_dst, wr_pair, wr_prod, res_hi, res_lo, flags, flag_we}, 33'h0)
		@(posedge mclk);
		arst_n <= 1'b1;
		// a request may already be taken on the first edge after release
		start <= 1'b1;
		op <= OP_ADD;
		{dst_val, src_val} <= {8'h21, 8'h12};
		#1;
		`CHK({busy, done, res_lo}, 10'h000)
		@(posedge mclk);
		start <= 1'b0;
		#1;
		`CHK({done, wr_dst, res_lo}, 10'h333)
		end_of_test();
	end
endmodule

// ===== sim/reg_file_model.sv
`timescale 1ns/1ps
// far-side register file: commits write-backs the way the core would
module reg_file_model (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic wr_dst,
	input wire logic wr_pair,
	input wire logic wr_prod,
	input wire logic [7:0] res_lo,
	input wire logic [7:0] res_hi,
	output logic [15:0] stored,
	output logic [2:0] last_wr
);
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			stored <= 16'h0000;
			last_wr <= 3'h0;
		end else if (wr_dst || wr_pair || wr_prod) begin
			// a byte write-back stores res_lo in the low byte and clears the high byte
			stored <= wr_dst ? {8'h00, res_lo} : {res_hi, res_lo};
			last_wr <= {wr_prod, wr_pair, wr_dst};
		end
	end
endmodule
